// File: design/uer_pkg.sv
// Package with register map, field layout, encodings and carrier types of the receive error block.
package uer_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] UER_ADDR_RX_BUF = 16'hff0a;
	localparam logic [15:0] UER_ADDR_ERR_STAT = 16'hff53;
	localparam logic [15:0] UER_ADDR_MODE = 16'hff50;
	localparam logic [15:0] UER_ADDR_CTRL = 16'hff54;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int UER_MODE_POWER = 7;
	localparam int UER_MODE_RXE = 5;
	localparam int UER_MODE_PS_HI = 4;
	localparam int UER_MODE_PS_LO = 3;
	localparam int UER_MODE_LEN8 = 2;
	localparam int UER_CTRL_BRK_FLAG = 7;
	localparam int UER_CTRL_BRK_TRIG = 6;
	localparam int UER_STAT_PE = 2;
	localparam int UER_STAT_FE = 1;
	localparam int UER_STAT_OVE = 0;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] UER_ERR_STAT_RST = 8'h00;
	localparam logic [7:0] UER_RX_BUF_RST = 8'hff;
	localparam logic [7:0] UER_MODE_RST = 8'h00;
	localparam logic [7:0] UER_CTRL_RST = 8'h00;
	localparam logic [4:0] UER_BRK_MIN_BITS = 5'h0b;
	localparam logic [3:0] UER_BITS_LEN8 = 4'h8;
	localparam logic [3:0] UER_BITS_LEN7 = 4'h7;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		UER_PAR_NONE = 2'h0,
		UER_PAR_ZERO = 2'h1,
		UER_PAR_ODD = 2'h2,
		UER_PAR_EVEN = 2'h3
	} uer_parity_t;

	typedef enum logic [2:0] {
		UER_ST_IDLE = 3'h0,
		UER_ST_START = 3'h1,
		UER_ST_DATA = 3'h3,
		UER_ST_PAR = 3'h2,
		UER_ST_STOP = 3'h6,
		UER_ST_BRK = 3'h7
	} uer_state_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} uer_req_t;

	typedef struct packed {
		logic rvalid;
		logic wait_cyc;
		logic [7:0] rdata;
	} uer_rsp_t;

endpackage

// File: design/uer_rx_error.sv
// Receive side of the asynchronous serial port with error status and break field reception.
`timescale 1ns/1ps
`default_nettype none

module uer_rx_error #(
	parameter int BAUD_DIV = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Register access
	input wire uer_pkg::uer_req_t sfr_req,
	output uer_pkg::uer_rsp_t sfr_rsp,
	// Serial line
	input wire logic serial_rx_pin,
	// Transmit parity helper
	input wire logic [7:0] tx_data,
	output logic tx_parity_bit,
	output logic tx_parity_en,
	// Events and settings
	output logic rx_complete_irq,
	output logic rx_active
);
	import uer_pkg::*;

	localparam logic [15:0] DIV_FULL = 16'(BAUD_DIV - 1);
	localparam logic [15:0] DIV_HALF = 16'(BAUD_DIV / 2 - 1);

	// ----------------------------------------------------------------
	// Parity functions
	// ----------------------------------------------------------------
	function automatic logic tx_parity(input logic [7:0] d, input uer_parity_t ps);
		case (ps)
			UER_PAR_EVEN: return ^d;
			UER_PAR_ODD: return ~(^d);
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic parity_bad(input logic [7:0] d, input logic p, input uer_parity_t ps);
		case (ps)
			UER_PAR_EVEN: return ^{d, p};
			UER_PAR_ODD: return ~(^{d, p});
			default: return 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Line synchroniser
	// ----------------------------------------------------------------
	logic rx_meta, rx_sync, rx_prev;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_meta <= serial_rx_pin;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	// ----------------------------------------------------------------
	// Register state declarations
	// ----------------------------------------------------------------
	logic [7:0] mode, rx_buf;
	logic brk_trig, brk_flag;
	logic [2:0] err_stat;
	logic buf_full, stat_pend;

	uer_parity_t psel;
	logic rx_on;
	assign psel = uer_parity_t'(mode[UER_MODE_PS_HI:UER_MODE_PS_LO]);
	assign rx_on = mode[UER_MODE_POWER] & mode[UER_MODE_RXE];

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	uer_state_t state, next_state;
	logic [15:0] cnt, next_cnt;
	logic [3:0] bitn, next_bitn;
	logic [7:0] shreg, next_shreg;
	logic parbit, next_parbit;
	logic [4:0] brk_len, next_brk_len;
	logic ev_done, ev_stop_ok, ev_brk_start, ev_brk_end;
	logic [3:0] nbits;
	logic [7:0] rx_word;

	assign nbits = mode[UER_MODE_LEN8] ? UER_BITS_LEN8 : UER_BITS_LEN7;
	assign rx_word = mode[UER_MODE_LEN8] ? shreg : {1'b0, shreg[7:1]};

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_bitn = bitn;
		next_shreg = shreg;
		next_parbit = parbit;
		next_brk_len = brk_len;
		ev_done = 1'b0;
		ev_stop_ok = 1'b0;
		ev_brk_start = 1'b0;
		ev_brk_end = 1'b0;
		if (!rx_on) begin
			next_state = UER_ST_IDLE;
		end else if (state == UER_ST_IDLE) begin
			// Only a falling edge starts a frame, so a line held low is not re-read.
			if (rx_prev && !rx_sync) begin
				next_state = UER_ST_START;
				next_cnt = DIV_HALF;
			end
		end else if (cnt != 16'h0000) begin
			next_cnt = cnt - 16'h0001;
		end else begin
			next_cnt = DIV_FULL;
			case (state)
				UER_ST_START: begin
					if (rx_sync) begin
						next_state = UER_ST_IDLE;
					end else if (brk_trig) begin
						next_state = UER_ST_BRK;
						next_brk_len = 5'h01;
						ev_brk_start = 1'b1;
					end else begin
						next_state = UER_ST_DATA;
						next_bitn = 4'h0;
					end
				end
				UER_ST_DATA: begin
					next_shreg = {rx_sync, shreg[7:1]};
					next_bitn = bitn + 4'h1;
					if (bitn == nbits - 4'h1) begin
						next_state = (psel == UER_PAR_NONE) ? UER_ST_STOP : UER_ST_PAR;
					end
				end
				UER_ST_PAR: begin
					next_parbit = rx_sync;
					next_state = UER_ST_STOP;
				end
				UER_ST_STOP: begin
					// Further stop bits are never sampled; the line simply idles high.
					ev_done = 1'b1;
					ev_stop_ok = rx_sync;
					next_state = UER_ST_IDLE;
				end
				UER_ST_BRK: begin
					if (rx_sync) begin
						ev_brk_end = 1'b1;
						next_state = UER_ST_IDLE;
					end else if (brk_len != 5'h1f) begin
						next_brk_len = brk_len + 5'h01;
					end
				end
				default: next_state = UER_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= UER_ST_IDLE;
			cnt <= 16'h0000;
			bitn <= 4'h0;
			shreg <= 8'h00;
			parbit <= 1'b0;
			brk_len <= 5'h00;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			bitn <= next_bitn;
			shreg <= next_shreg;
			parbit <= next_parbit;
			brk_len <= next_brk_len;
		end
	end

	// ----------------------------------------------------------------
	// Registers, status and CPU access
	// ----------------------------------------------------------------
	logic [7:0] next_mode, next_rx_buf;
	logic next_brk_trig, next_brk_flag;
	logic [2:0] next_err_stat;
	logic next_buf_full, next_stat_pend, next_irq, next_tx_par, next_tx_par_en;
	uer_rsp_t next_rsp;
	logic brk_ok, disable_wr, buf_rd;

	assign brk_ok = ev_brk_end && (brk_len >= UER_BRK_MIN_BITS);
	assign disable_wr = sfr_req.wr && !stat_pend && (sfr_req.addr == UER_ADDR_MODE)
		&& !(sfr_req.wdata[UER_MODE_POWER] && sfr_req.wdata[UER_MODE_RXE]);
	// A buffer read in the completion cycle frees the buffer, so the new character is kept.
	assign buf_rd = sfr_req.rd && !stat_pend && (sfr_req.addr == UER_ADDR_RX_BUF);

	always_comb begin
		next_mode = mode;
		next_brk_trig = brk_trig;
		next_brk_flag = brk_flag;
		next_err_stat = err_stat;
		next_rx_buf = rx_buf;
		next_buf_full = buf_full;
		next_stat_pend = 1'b0;
		next_irq = 1'b0;
		next_rsp = '0;
		next_tx_par = tx_parity(tx_data, psel);
		next_tx_par_en = (psel != UER_PAR_NONE);
		// Clear by status read first, so a same-cycle error below still wins.
		if (stat_pend) begin
			next_rsp.rvalid = 1'b1;
			next_rsp.rdata = {5'h00, err_stat};
			next_err_stat = 3'h0;
		end else if (sfr_req.rd) begin
			case (sfr_req.addr)
				UER_ADDR_ERR_STAT: begin
					next_rsp.wait_cyc = 1'b1;
					next_stat_pend = 1'b1;
				end
				UER_ADDR_RX_BUF: begin
					next_rsp.rvalid = 1'b1;
					next_rsp.rdata = rx_buf;
					next_buf_full = 1'b0;
				end
				UER_ADDR_MODE: begin
					next_rsp.rvalid = 1'b1;
					next_rsp.rdata = mode;
				end
				UER_ADDR_CTRL: begin
					next_rsp.rvalid = 1'b1;
					next_rsp.rdata = {brk_flag, brk_trig, 6'h00};
				end
				default: begin
					next_rsp.rvalid = 1'b1;
					next_rsp.rdata = 8'h00;
				end
			endcase
		end
		if (ev_done && !brk_trig) begin
			next_irq = 1'b1;
			if (parity_bad(rx_word, parbit, psel)) begin
				next_err_stat[UER_STAT_PE] = 1'b1;
			end
			if (!ev_stop_ok) begin
				next_err_stat[UER_STAT_FE] = 1'b1;
			end
			if (buf_full && !buf_rd) begin
				next_err_stat[UER_STAT_OVE] = 1'b1;
			end else begin
				next_rx_buf = rx_word;
				next_buf_full = 1'b1;
			end
		end
		// Break frames leave status and buffer untouched.
		if (ev_brk_start) begin
			next_brk_flag = 1'b1;
		end
		if (brk_ok) begin
			next_irq = 1'b1;
			next_brk_trig = 1'b0;
			next_brk_flag = 1'b0;
		end
		// A short break leaves brk_trig and brk_flag set and waits for the next start bit.
		if (sfr_req.wr && !stat_pend) begin
			case (sfr_req.addr)
				UER_ADDR_MODE: begin
					next_mode = sfr_req.wdata;
					// Receive enable only takes when power was already on.
					next_mode[UER_MODE_RXE] = sfr_req.wdata[UER_MODE_RXE]
						& mode[UER_MODE_POWER] & sfr_req.wdata[UER_MODE_POWER];
				end
				UER_ADDR_CTRL: begin
					next_brk_trig = sfr_req.wdata[UER_CTRL_BRK_TRIG];
				end
				default: ;
			endcase
		end
		if (disable_wr) begin
			next_err_stat = UER_ERR_STAT_RST[2:0];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode <= UER_MODE_RST;
			brk_trig <= UER_CTRL_RST[UER_CTRL_BRK_TRIG];
			brk_flag <= UER_CTRL_RST[UER_CTRL_BRK_FLAG];
			err_stat <= UER_ERR_STAT_RST[2:0];
			rx_buf <= UER_RX_BUF_RST;
			buf_full <= 1'b0;
			stat_pend <= 1'b0;
			rx_complete_irq <= 1'b0;
			sfr_rsp <= '0;
			tx_parity_bit <= 1'b0;
			tx_parity_en <= 1'b0;
			rx_active <= 1'b0;
		end else begin
			mode <= next_mode;
			brk_trig <= next_brk_trig;
			brk_flag <= next_brk_flag;
			err_stat <= next_err_stat;
			rx_buf <= next_rx_buf;
			buf_full <= next_buf_full;
			stat_pend <= next_stat_pend;
			rx_complete_irq <= next_irq;
			sfr_rsp <= next_rsp;
			tx_parity_bit <= next_tx_par;
			tx_parity_en <= next_tx_par_en;
			rx_active <= next_mode[UER_MODE_POWER] & next_mode[UER_MODE_RXE];
		end
	end

endmodule

`default_nettype wire

// File: test/test_uer_rx_error.sv
// Self-checking bench for the receive error block.
`timescale 1ns/1ps
`default_nettype none

module test_uer_rx_error;
	import uer_pkg::*;
	localparam int DIV = 16;
	logic mclk;
	logic arst_n;
	uer_req_t req;
	uer_rsp_t rsp;
	logic line;
	logic [7:0] tx_data;
	logic irq;
	logic act;
	int bad_count;
	int checks_done;
	int irqs;
	int ni;
	logic [7:0] rv;
	logic [7:0] d0;
	logic [7:0] d1;

	uer_rx_error #(.BAUD_DIV(DIV)) DUT (
		.mclk(mclk), .arst_n(arst_n), .sfr_req(req), .sfr_rsp(rsp),
		.serial_rx_pin(line), .tx_data(tx_data), .tx_parity_bit(), .tx_parity_en(),
		.rx_complete_irq(irq), .rx_active(act));
	uer_node #(.BAUD_DIV(DIV)) node (.mclk(mclk), .line(line));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (irq === 1'b1) irqs++;
		tx_data <= 8'($urandom);
	end

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", w, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge mclk);
		req.wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge mclk);
		req.rd <= 1'b0;
		d = 8'hxx;
		repeat (4) begin
			@(posedge mclk);
			if (rsp.rvalid === 1'b1) begin
				d = rsp.rdata;
				break;
			end
		end
	endtask
	task automatic rchk(input string w, input logic [15:0] a, input logic [7:0] e);
		rd(a, rv);
		check(w, rv, e);
	endtask
	task automatic en(input logic [1:0] m);
		wr(UER_ADDR_MODE, {3'h4, m, 3'h4});
		wr(UER_ADDR_MODE, {3'h5, m, 3'h4});
		@(posedge mclk);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		#600000;
		bad_count++;
		summarize();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'hbe53));
		arst_n = 1'b0;
		req = '0;
		bad_count = 0;
		checks_done = 0;
		irqs = 0;
		ni = 0;
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		rchk("status", UER_ADDR_ERR_STAT, UER_ERR_STAT_RST);
		rchk("buffer", UER_ADDR_RX_BUF, UER_RX_BUF_RST);
		rchk("unmapped", 16'hff00, 8'h00);
		wr(UER_ADDR_MODE, 8'ha4);
		@(posedge mclk);
		check("active early", {7'h0, act}, 8'h00);
		en(2'h0);
		check("active", {7'h0, act}, 8'h01);
		wr(UER_ADDR_CTRL, 8'h40);
		node.brk(10);
		check("short irq", 8'(irqs), 8'(ni));
		rd(UER_ADDR_CTRL, rv);
		check("short ctrl", rv & 8'hc0, 8'hc0);
		node.brk(11);
		ni++;
		check("long irq", 8'(irqs), 8'(ni));
		rd(UER_ADDR_CTRL, rv);
		check("long ctrl", rv & 8'hc0, 8'h00);
		rchk("brk status", UER_ADDR_ERR_STAT, 8'h00);
		rchk("brk buffer", UER_ADDR_RX_BUF, UER_RX_BUF_RST);
		for (int m = 0; m < 4; m++) begin
			en(m[1:0]);
			d0 = (m == 0) ? 8'hff : 8'($urandom);
			node.send(d0, m[1:0], 1'b0, 1'b1);
			rchk("good", UER_ADDR_ERR_STAT, 8'h00);
			rchk("data", UER_ADDR_RX_BUF, d0);
			node.send(d0, m[1:0], 1'b1, 1'b1);
			ni += 2;
			rchk("parity", UER_ADDR_ERR_STAT, {5'h0, m[1], 2'h0});
			rchk("data bad", UER_ADDR_RX_BUF, d0);
		end
		node.send(d0, 2'h3, 1'b0, 1'b0);
		ni++;
		check("irqs", 8'(irqs), 8'(ni));
		rchk("framing", UER_ADDR_ERR_STAT, 8'h02);
		rchk("cleared", UER_ADDR_ERR_STAT, 8'h00);
		rd(UER_ADDR_RX_BUF, rv);
		d1 = 8'($urandom);
		node.send(d0, 2'h3, 1'b0, 1'b1);
		node.send(d1, 2'h3, 1'b0, 1'b1);
		rchk("overrun", UER_ADDR_ERR_STAT, 8'h01);
		rchk("kept", UER_ADDR_RX_BUF, d0);
		node.send(d1, 2'h3, 1'b1, 1'b1);
		wr(UER_ADDR_MODE, 8'h9c);
		en(2'h3);
		rchk("off clear", UER_ADDR_ERR_STAT, 8'h00);
		rchk("last", UER_ADDR_RX_BUF, d1);
		wr(UER_ADDR_MODE, 8'h98);
		wr(UER_ADDR_MODE, 8'hb8);
		node.send({^d1[6:0], d1[6:0]}, 2'h0, 1'b0, 1'b1);
		rchk("short word", UER_ADDR_ERR_STAT, 8'h00);
		rchk("short data", UER_ADDR_RX_BUF, {1'b0, d1[6:0]});
		node.send({~^d1[6:0], d1[6:0]}, 2'h0, 1'b0, 1'b1);
		rchk("short parity", UER_ADDR_ERR_STAT, 8'h04);
		node.send({~^d1[6:0], d1[6:0]}, 2'h0, 1'b0, 1'b1);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		rchk("reset status", UER_ADDR_ERR_STAT, UER_ERR_STAT_RST);
		check("reset active", {7'h0, act}, 8'h00);
		summarize();
	end
endmodule

bind uer_rx_error uer_props #(.BAUD_DIV(BAUD_DIV)) props_i (
	.mclk(mclk), .arst_n(arst_n), .sfr_req(sfr_req), .sfr_rsp(sfr_rsp),
	.serial_rx_pin(serial_rx_pin), .tx_data(tx_data), .tx_parity_bit(tx_parity_bit),
	.tx_parity_en(tx_parity_en), .rx_complete_irq(rx_complete_irq), .rx_active(rx_active));

`default_nettype wire

// File: test/uer_node.sv
// Remote serial node driving frames and break fields onto the receive line.
`timescale 1ns/1ps
`default_nettype none

module uer_node #(
	parameter int BAUD_DIV = 16
) (
	// Clock and line
	input wire logic mclk,
	output var logic line
);
	import uer_pkg::*;

	initial begin
		line = 1'b1;
	end
	task automatic bit_out(input logic b);
		line <= b;
		repeat (BAUD_DIV) @(posedge mclk);
	endtask
	task automatic send(input logic [7:0] d, input logic [1:0] m, input logic flip, input logic stp);
		logic p;
		p = (m == UER_PAR_EVEN) ? ^d : (m == UER_PAR_ODD) ? ~^d : 1'b0;
		bit_out(1'b0);
		for (int i = 0; i < 8; i++) begin
			bit_out(d[i]);
		end
		if (m != UER_PAR_NONE) begin
			bit_out(p ^ flip);
		end
		bit_out(stp);
		bit_out(1'b1);
	endtask
	task automatic brk(input int n);
		repeat (n) bit_out(1'b0);
		bit_out(1'b1);
		bit_out(1'b1);
	endtask
endmodule

`default_nettype wire

// File: test/uer_props.sv
// Port assertions for the receive error block.
`timescale 1ns/1ps
`default_nettype none

module uer_props #(
	parameter int BAUD_DIV = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Register access
	input wire uer_pkg::uer_req_t sfr_req,
	input wire uer_pkg::uer_rsp_t sfr_rsp,
	// Serial side and events
	input wire logic serial_rx_pin,
	input wire logic [7:0] tx_data,
	input wire logic tx_parity_bit,
	input wire logic tx_parity_en,
	input wire logic rx_complete_irq,
	input wire logic rx_active
);
	import uer_pkg::*;
	logic [1:0] ps;
	logic [1:0] next_ps;
	logic st_rd;
	logic ot_rd;

	// The parity select is shadowed here because only the ports are visible.
	always_comb begin
		next_ps = ps;
		if (sfr_req.wr && !sfr_rsp.wait_cyc && sfr_req.addr == UER_ADDR_MODE) begin
			next_ps = sfr_req.wdata[UER_MODE_PS_HI:UER_MODE_PS_LO];
		end
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ps <= 2'h0;
		end else begin
			ps <= next_ps;
		end
	end
	assign st_rd = sfr_req.rd && sfr_req.addr == UER_ADDR_ERR_STAT && !sfr_rsp.wait_cyc;
	assign ot_rd = sfr_req.rd && sfr_req.addr != UER_ADDR_ERR_STAT && !sfr_rsp.wait_cyc;

	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	AST_STAT_WAIT: assert property (st_rd |=> sfr_rsp.wait_cyc && !sfr_rsp.rvalid ##1 sfr_rsp.rvalid)
		else $error("status read timing wrong");
	AST_STAT_HIGH: assert property (st_rd |-> ##2 sfr_rsp.rdata[7:3] == 5'h00)
		else $error("status upper bits not zero");
	AST_OTHER_RD: assert property (ot_rd |=> sfr_rsp.rvalid && !sfr_rsp.wait_cyc)
		else $error("plain read timing wrong");
	AST_PAR_EVEN: assert property (ps == UER_PAR_EVEN |=> tx_parity_bit == ^$past(tx_data))
		else $error("even parity bit wrong");
	AST_PAR_ODD: assert property (ps == UER_PAR_ODD |=> tx_parity_bit == ~^$past(tx_data))
		else $error("odd parity bit wrong");
	AST_PAR_ZERO: assert property (ps == UER_PAR_ZERO |=> !tx_parity_bit && tx_parity_en)
		else $error("zero parity bit wrong");
	AST_PAR_NONE: assert property (ps == UER_PAR_NONE |=> !tx_parity_en)
		else $error("parity enabled with none");
	AST_IRQ_PULSE: assert property (rx_complete_irq |=> !rx_complete_irq)
		else $error("completion pulse too long");
	AST_IDLE_QUIET: assert property ((!rx_active) [*3] |-> !rx_complete_irq)
		else $error("completion while disabled");
endmodule

`default_nettype wire
